// ### hdl/lsfs_pkg.sv
// Overview of operation
// - Bit 15 picks steady or flash mode
// - Bit 14 picks drive bit or pin trigger
// - Trigger source ignored in steady mode
// - Steady mode: bit 13 turns sink on/off
// - Drive bit rise flashes unless repeat set; self-clears at end
// - Pin source: drive writes never start flashes
// - Repeat clear: one flash per trigger
// - Repeat set: internal flash every 4 s
// - Bits 9:8 give 32/64/96/1024 ms pulse
// - Steady ramp: instant, 0.25, 0.5, 1 s
// - Flash ramp: instant, 1.95, 3.91, 7.8 ms
// - Power state reset clears control fields
package lsfs_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTRL_OFFSET   = 8'h00;
  localparam logic [7:0]  STATUS_OFFSET = 8'h04;
  localparam logic [15:0] CTRL_RESET    = 16'h0000;
  localparam logic [15:0] CTRL_MASK     = 16'hF330;
  localparam int MODE_BIT   = 15;
  localparam int TRIG_BIT   = 14;
  localparam int DRIVE_BIT  = 13;
  localparam int REPEAT_BIT = 12;
  localparam int DUR_LSB    = 8;
  localparam int RAMP_LSB   = 4;
  localparam int STAT_FLASH_BIT = 0;
  localparam int STAT_RAMP_BIT  = 1;
  localparam int STAT_MISS_BIT  = 2;
  localparam int STAT_LVL_LSB   = 8;

  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------
  localparam int CLOCK_NS    = 10;
  localparam int TICK_NS     = 10000;
  localparam int TICK_CYCLES = (TICK_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int TICKS_PER_MS = 1000000 / TICK_NS;
  localparam int TICKS_PER_S  = 1000000000 / TICK_NS;
  localparam int FLASH_MS0 = 32;
  localparam int FLASH_MS1 = 64;
  localparam int FLASH_MS2 = 96;
  localparam int FLASH_MS3 = 1024;
  localparam int REPEAT_S  = 4;
  localparam int LED_RAMP_MS1 = 250;
  localparam int LED_RAMP_MS2 = 500;
  localparam int LED_RAMP_MS3 = 1000;
  localparam int FL_RAMP_US1 = 1953;
  localparam int FL_RAMP_US2 = 3906;
  localparam int FL_RAMP_US3 = 7812;
  localparam int CNT_W = 19;
  localparam logic [CNT_W-1:0] REPEAT_TICKS = CNT_W'(REPEAT_S * TICKS_PER_S);
  localparam logic [6:0]       LEVEL_FULL   = 7'h7F;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic [CNT_W-1:0] lsfs_cnt_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_ON    = 4'b0010,
    ST_FLASH = 4'b0100,
    ST_RAMP  = 4'b1000
  } lsfs_state_e;

  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wrData;
    logic        wrEn;
    logic        rdEn;
  } lsfs_bus_s;

  typedef struct packed {
    lsfs_state_e st;
    logic [15:0] ctrl;
    logic        drivePrev;
    logic        pinPrev;
    logic [1:0]  pinSync;
    logic [15:0] preCnt;
    lsfs_cnt_t   phaseCnt;
    lsfs_cnt_t   repCnt;
    lsfs_cnt_t   rampTotal;
    lsfs_cnt_t   acc;
    logic [6:0]  level;
    logic        missed;
    logic [15:0] rdData;
  } lsfs_regs_s;

endpackage

// ### hdl/lsfs_top.sv
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ns
module lsfs_top #(
  parameter logic [15:0] TICK_CYCLES = 16'(lsfs_pkg::TICK_CYCLES)
) (
  input  wire logic               clock,
  input  wire logic               reset,
  input  wire logic               clockEnable,
  input  wire logic               pmReset,
  input  wire logic               flashPin,
  input  wire lsfs_pkg::lsfs_bus_s bus,
  output logic [15:0]             regReadData,
  output logic                    currentSinkOutputA,
  output logic [6:0]              sinkLevel,
  output logic                    flashActive
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  lsfs_pkg::lsfs_regs_s q;
  lsfs_pkg::lsfs_regs_s d;

  logic                tick;
  logic                flashMode;
  logic                pinSource;
  logic                driveBit;
  logic                repeatOn;
  logic [1:0]          durSel;
  logic [1:0]          rampSel;
  logic                ctrlWrite;
  logic                writeSetsDrive;
  logic                regTrig;
  logic                pinTrig;
  logic                repTrig;
  logic                trig;
  lsfs_pkg::lsfs_cnt_t durTicks;
  lsfs_pkg::lsfs_cnt_t rampTicks;
  lsfs_pkg::lsfs_cnt_t accSum;
  lsfs_pkg::lsfs_cnt_t accNext;
  logic                levelStep;
  logic                rampDone;
  logic                flashDone;
  logic                clearDrive;
  logic [15:0]         statusWord;

  // ----------------------------------------------------------------
  // Lookup of pulse and ramp lengths in ticks
  // ----------------------------------------------------------------
  function automatic lsfs_pkg::lsfs_cnt_t flashLen(input logic [1:0] sel);
    lsfs_pkg::lsfs_cnt_t t;
    t = '0;
    case (sel)
      2'b00:   t = 19'(lsfs_pkg::FLASH_MS0 * lsfs_pkg::TICKS_PER_MS);
      2'b01:   t = 19'(lsfs_pkg::FLASH_MS1 * lsfs_pkg::TICKS_PER_MS);
      2'b10:   t = 19'(lsfs_pkg::FLASH_MS2 * lsfs_pkg::TICKS_PER_MS);
      default: t = 19'(lsfs_pkg::FLASH_MS3 * lsfs_pkg::TICKS_PER_MS);
    endcase
    return t;
  endfunction

  function automatic lsfs_pkg::lsfs_cnt_t rampLen(input logic fl,
                                                  input logic [1:0] sel);
    lsfs_pkg::lsfs_cnt_t t;
    t = '0;
    if (fl) begin
      case (sel)
        2'b00:   t = '0;
        2'b01:   t = 19'(lsfs_pkg::FL_RAMP_US1 * lsfs_pkg::TICKS_PER_MS / 1000);
        2'b10:   t = 19'(lsfs_pkg::FL_RAMP_US2 * lsfs_pkg::TICKS_PER_MS / 1000);
        default: t = 19'(lsfs_pkg::FL_RAMP_US3 * lsfs_pkg::TICKS_PER_MS / 1000);
      endcase
    end else begin
      case (sel)
        2'b00:   t = '0;
        2'b01:   t = 19'(lsfs_pkg::LED_RAMP_MS1 * lsfs_pkg::TICKS_PER_MS);
        2'b10:   t = 19'(lsfs_pkg::LED_RAMP_MS2 * lsfs_pkg::TICKS_PER_MS);
        default: t = 19'(lsfs_pkg::LED_RAMP_MS3 * lsfs_pkg::TICKS_PER_MS);
      endcase
    end
    return t;
  endfunction

  // ----------------------------------------------------------------
  // Field and write decode
  // ----------------------------------------------------------------

  // Control fields as currently held
  always_comb begin
    flashMode = q.ctrl[lsfs_pkg::MODE_BIT];
    pinSource = q.ctrl[lsfs_pkg::TRIG_BIT];
    driveBit  = q.ctrl[lsfs_pkg::DRIVE_BIT];
    repeatOn  = q.ctrl[lsfs_pkg::REPEAT_BIT];
    durSel    = q.ctrl[lsfs_pkg::DUR_LSB +: 2];
    rampSel   = q.ctrl[lsfs_pkg::RAMP_LSB +: 2];
  end

  // Write decode for the control word
  always_comb begin
    ctrlWrite      = bus.wrEn && (bus.addr == lsfs_pkg::CTRL_OFFSET);
    writeSetsDrive = ctrlWrite && bus.wrData[lsfs_pkg::DRIVE_BIT];
  end

  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------

  // Shared prescaler tick
  always_comb begin
    tick = (q.preCnt == (TICK_CYCLES - 16'h0001));
  end

  // ----------------------------------------------------------------
  // Trigger sources
  // ----------------------------------------------------------------

  // Edge detectors on drive bit and synchronised pin
  always_comb begin
    regTrig = !pinSource && driveBit && !q.drivePrev;
    pinTrig = pinSource && q.pinSync[1] && !q.pinPrev;
  end

  // Internal repeat trigger every interval
  always_comb begin
    repTrig = flashMode && repeatOn && tick &&
              (q.repCnt == (lsfs_pkg::REPEAT_TICKS - 19'h0_0001));
  end

  // Flash start request, only in flash mode
  always_comb begin
    trig = flashMode && (repeatOn ? repTrig : (regTrig || pinTrig));
  end

  // ----------------------------------------------------------------
  // Programmed lengths
  // ----------------------------------------------------------------

  // Programmed lengths for the present settings
  always_comb begin
    durTicks  = flashLen(durSel);
    rampTicks = rampLen(flashMode, rampSel);
  end

  // ----------------------------------------------------------------
  // Pulse end
  // ----------------------------------------------------------------

  // Last tick of the pulse; hardware drive clear yields to a setting write
  always_comb begin
    flashDone  = tick && (q.phaseCnt == (durTicks - 19'h0_0001));
    clearDrive = !pinSource && !writeSetsDrive;
  end

  // ----------------------------------------------------------------
  // Ramp arithmetic
  // ----------------------------------------------------------------

  // Level falls by one each time the accumulator passes the ramp length
  always_comb begin
    accSum    = q.acc + 19'(lsfs_pkg::LEVEL_FULL);
    levelStep = (accSum >= q.rampTotal);
    accNext   = levelStep ? (accSum - q.rampTotal) : accSum;
    rampDone  = (q.phaseCnt == (q.rampTotal - 19'h0_0001));
  end

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------

  // Pulse, ramp, missed trigger and level for software
  always_comb begin
    statusWord = 16'h0000;
    statusWord[lsfs_pkg::STAT_FLASH_BIT]    = (q.st == lsfs_pkg::ST_FLASH);
    statusWord[lsfs_pkg::STAT_RAMP_BIT]     = (q.st == lsfs_pkg::ST_RAMP);
    statusWord[lsfs_pkg::STAT_MISS_BIT]     = q.missed;
    statusWord[lsfs_pkg::STAT_LVL_LSB +: 7] = q.level;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    if (clockEnable) begin
      d.rdData = 16'h0000;
      // Pin synchroniser and edge history
      d.pinSync   = {q.pinSync[0], flashPin};
      d.pinPrev   = q.pinSync[1];
      d.drivePrev = driveBit;
      d.preCnt    = tick ? 16'h0000 : q.preCnt + 16'h0001;

      // Software access
      if (ctrlWrite) begin
        d.ctrl = bus.wrData & lsfs_pkg::CTRL_MASK;
      end
      if (bus.rdEn) begin
        case (bus.addr)
          lsfs_pkg::CTRL_OFFSET: begin
            d.rdData = q.ctrl;
          end
          lsfs_pkg::STATUS_OFFSET: begin
            d.rdData = statusWord;
            d.missed = 1'b0;
          end
          default: begin
            d.rdData = 16'h0000;
          end
        endcase
      end

      // Repeat interval counter
      if (flashMode && repeatOn) begin
        if (tick) begin
          d.repCnt = repTrig ? '0 : q.repCnt + 19'h0_0001;
        end
      end else begin
        d.repCnt = '0;
      end

      // Sink sequencer
      case (q.st)
        lsfs_pkg::ST_IDLE: begin
          d.level = 7'h00;
          if (!flashMode && driveBit) begin
            d.st    = lsfs_pkg::ST_ON;
            d.level = lsfs_pkg::LEVEL_FULL;
          end else if (trig) begin
            d.st       = lsfs_pkg::ST_FLASH;
            d.phaseCnt = '0;
            d.level    = lsfs_pkg::LEVEL_FULL;
          end
        end
        lsfs_pkg::ST_ON: begin
          d.level = lsfs_pkg::LEVEL_FULL;
          if (flashMode) begin
            d.st    = lsfs_pkg::ST_IDLE;
            d.level = 7'h00;
          end else if (!driveBit) begin
            d.phaseCnt  = '0;
            d.acc       = '0;
            d.rampTotal = rampTicks;
            if (rampTicks == '0) begin
              d.st    = lsfs_pkg::ST_IDLE;
              d.level = 7'h00;
            end else begin
              d.st = lsfs_pkg::ST_RAMP;
            end
          end
        end
        lsfs_pkg::ST_FLASH: begin
          if (trig) begin
            d.missed = 1'b1;
          end
          if (!flashMode) begin
            d.st    = lsfs_pkg::ST_IDLE;
            d.level = 7'h00;
          end else if (flashDone) begin
            if (clearDrive) begin
              d.ctrl[lsfs_pkg::DRIVE_BIT] = 1'b0;
            end
            d.phaseCnt  = '0;
            d.acc       = '0;
            d.rampTotal = rampTicks;
            if (rampTicks == '0) begin
              d.st    = lsfs_pkg::ST_IDLE;
              d.level = 7'h00;
            end else begin
              d.st = lsfs_pkg::ST_RAMP;
            end
          end else if (tick) begin
            d.phaseCnt = q.phaseCnt + 19'h0_0001;
          end
        end
        lsfs_pkg::ST_RAMP: begin
          if (flashMode && trig) begin
            d.missed = 1'b1;
          end
          if (!flashMode && driveBit) begin
            d.st    = lsfs_pkg::ST_ON;
            d.level = lsfs_pkg::LEVEL_FULL;
          end else if (tick) begin
            if (rampDone) begin
              d.st    = lsfs_pkg::ST_IDLE;
              d.level = 7'h00;
            end else begin
              d.phaseCnt = q.phaseCnt + 19'h0_0001;
              d.acc      = accNext;
              if (levelStep) begin
                d.level = q.level - 7'h01;
              end
            end
          end
        end
        default: begin
          d.st    = lsfs_pkg::ST_IDLE;
          d.level = 7'h00;
        end
      endcase

      // Power state machine reset clears fields and sequencer
      if (pmReset) begin
        d.ctrl      = lsfs_pkg::CTRL_RESET;
        d.st        = lsfs_pkg::ST_IDLE;
        d.level     = 7'h00;
        d.phaseCnt  = '0;
        d.repCnt    = '0;
        d.acc       = '0;
        d.rampTotal = '0;
        d.missed    = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register stage
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      q.st        <= lsfs_pkg::ST_IDLE;
      q.ctrl      <= lsfs_pkg::CTRL_RESET;
      q.drivePrev <= 1'b0;
      q.pinPrev   <= 1'b0;
      q.pinSync   <= 2'b00;
      q.preCnt    <= 16'h0000;
      q.phaseCnt  <= '0;
      q.repCnt    <= '0;
      q.rampTotal <= '0;
      q.acc       <= '0;
      q.level     <= 7'h00;
      q.missed    <= 1'b0;
      q.rdData    <= 16'h0000;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign regReadData        = q.rdData;
  assign sinkLevel          = q.level;
  assign currentSinkOutputA = (q.level != 7'h00);
  assign flashActive        = (q.st == lsfs_pkg::ST_FLASH);

endmodule

// ### test/lsfs_checker_sva.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Port checker for the sink sequencer
// ----------------------------------------------------------------
module lsfs_checker #(
  parameter logic [15:0] TICK_CYCLES = 16'h0002
) (
  input wire logic                clock,
  input wire logic                reset,
  input wire logic                clockEnable,
  input wire logic                pmReset,
  input wire logic                flashPin,
  input wire lsfs_pkg::lsfs_bus_s bus,
  input wire logic [15:0]         regReadData,
  input wire logic                currentSinkOutputA,
  input wire logic [6:0]          sinkLevel,
  input wire logic                flashActive
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  // Control word write, taken and not cleared
  sequence s_wr_ctrl;
    bus.wrEn && bus.addr == 8'h00 && clockEnable && !pmReset;
  endsequence
  // Steady mode write with drive set
  sequence s_led_on;
    s_wr_ctrl ##0 (!bus.wrData[15] && bus.wrData[13]);
  endsequence
  // Steady mode write, drive clear, no ramp
  sequence s_led_off;
    s_wr_ctrl ##0 (!bus.wrData[15] && !bus.wrData[13] && bus.wrData[5:4] == 2'b00);
  endsequence
  // Read of control two cycles after a write
  sequence s_wr_then_rd;
    (s_wr_ctrl ##0 !bus.wrData[15]) ##2 (bus.rdEn && bus.addr == 8'h00 && clockEnable);
  endsequence

  a_read_idle_zero: assert property ($past(clockEnable) && !$past(bus.rdEn) |-> regReadData == 16'h0000)
    else $error("read data not zero outside read answer");
  a_sink_level_tie: assert property (currentSinkOutputA == (sinkLevel != 7'h00))
    else $error("sink enable disagrees with level");
  a_flash_full_level: assert property (flashActive |-> sinkLevel == 7'h7F)
    else $error("flash pulse not at full level");
  a_led_drive_on: assert property (s_led_on |-> ##2 sinkLevel == 7'h7F)
    else $error("steady drive did not switch sink on");
  a_led_instant_off: assert property (s_led_off |-> ##[1:2] sinkLevel == 7'h00)
    else $error("instant switch off not seen");
  a_ctrl_readback: assert property (s_wr_then_rd |=>
    regReadData == ($past(bus.wrData, 3) & lsfs_pkg::CTRL_MASK))
    else $error("control readback wrong");
  a_pm_clears: assert property (pmReset && clockEnable |=> sinkLevel == 7'h00 && !flashActive)
    else $error("power state reset left sink active");
  a_flash_min_pulse: assert property ($rose(flashActive) |-> flashActive [*8])
    else $error("flash pulse too short");
endmodule

// ### test/testbench.sv
`timescale 1ns/1ns
module testbench;
  localparam int T = 2;
  logic                clock;
  logic                reset;
  logic                clockEnable;
  logic                pmReset;
  logic                flashPin;
  lsfs_pkg::lsfs_bus_s bus;
  logic [15:0]         regReadData;
  logic                currentSinkOutputA;
  logic [6:0]          sinkLevel;
  logic                flashActive;
  logic [15:0]         rdv;
  int                  mismatches;
  int                  total_checks;
  int                  durs [3] = '{3200, 6400, 9600};
  int                  ramps [3] = '{0, 195, 390};

  // Clock generation
  initial clock = 1'b0;
  always #5 clock = ~clock;

  lsfs_top #(.TICK_CYCLES(16'h0002)) dut (
    .clock(clock), .reset(reset), .clockEnable(clockEnable), .pmReset(pmReset),
    .flashPin(flashPin), .bus(bus), .regReadData(regReadData),
    .currentSinkOutputA(currentSinkOutputA), .sinkLevel(sinkLevel), .flashActive(flashActive)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_up;
    mismatches++;
    $display("mismatch at %0t: wait timed out", $time);
    tally_and_finish();
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    bus.addr <= a;
    bus.wrData <= d;
    bus.wrEn <= 1'b1;
    @(posedge clock);
    bus.wrEn <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock);
    bus.addr <= a;
    bus.rdEn <= 1'b1;
    @(posedge clock);
    bus.rdEn <= 1'b0;
    #1;
    d = regReadData;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wait_flash(input logic v, output int n);
    n = 0;
    while (flashActive !== v && n < 30000) begin
      idle(1);
      n++;
    end
    if (n == 30000) give_up();
  endtask

  // Pulse length and ramp length, within two ticks plus four clocks of jitter
  task automatic meas(input int durT, input int rampT);
    int n;
    int m;
    wait_flash(1'b1, n);
    wait_flash(1'b0, n);
    m = 0;
    while (sinkLevel !== 7'h00 && m < 2000) begin
      idle(1);
      m++;
    end
    if (m == 2000) give_up();
    check(n > durT * T - 2 * T - 4 && n < durT * T + 2 * T + 4, 1);
    check(m + 2 * T + 4 > rampT * T && m < rampT * T + 2 * T + 4, 1);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_led;
    rd(8'h00, rdv);
    check(rdv, 16'h0000);
    rd(8'h08, rdv);
    check(rdv, 16'h0000);
    wr(8'h00, 16'h2C3F);
    rd(8'h00, rdv);
    check(rdv, 16'h2C3F & lsfs_pkg::CTRL_MASK);
    check(sinkLevel, 7'h7F);
    check(currentSinkOutputA, 1'b1);
    // Frozen clock enable: a write is not taken
    @(posedge clock);
    clockEnable <= 1'b0;
    wr(8'h00, 16'h0000);
    idle(2);
    check(sinkLevel, 7'h7F);
    @(posedge clock);
    clockEnable <= 1'b1;
    wr(8'h00, 16'h0000);
    idle(2);
    check(sinkLevel, 7'h00);
    check(currentSinkOutputA, 1'b0);
    wr(8'h00, 16'h6000);
    idle(1);
    check({flashActive, sinkLevel}, 8'h7F);
    wr(8'h00, 16'h0010);
    idle(1000);
    check(sinkLevel > 7'h00 && sinkLevel < 7'h7F, 1'b1);
    wr(8'h00, 16'h2000);
    idle(1);
    check(sinkLevel, 7'h7F);
    wr(8'h00, 16'h0000);
    idle(2);
    check(sinkLevel, 7'h00);
    $display("test_led done");
  endtask

  task automatic test_flash;
    for (int d = 0; d < 3; d++) begin
      wr(8'h00, 16'h8000 | 16'(d << 8) | 16'(d << 4));
      wr(8'h00, 16'hA000 | 16'(d << 8) | 16'(d << 4));
      meas(durs[d], ramps[d]);
      rd(8'h00, rdv);
      check(rdv[13], 1'b0);
      idle(20);
      check(flashActive, 1'b0);
    end
    $display("test_flash done");
  endtask

  task automatic test_busy;
    int n;
    wr(8'h00, 16'h8000);
    wr(8'h00, 16'hA000);
    idle(10);
    wr(8'h00, 16'h8000);
    wr(8'h00, 16'hA000);
    wait_flash(1'b0, n);
    idle(20);
    check(flashActive, 1'b0);
    rd(8'h04, rdv);
    check(rdv[2], 1'b1);
    $display("test_busy done");
  endtask

  task automatic test_pin;
    wr(8'h00, 16'hC000);
    wr(8'h00, 16'hE000);
    idle(10);
    check(flashActive, 1'b0);
    flashPin <= 1'b1;
    meas(3200, 0);
    idle(20);
    check(flashActive, 1'b0);
    flashPin <= 1'b0;
    $display("test_pin done");
  endtask

  task automatic test_repeat_pm;
    wr(8'h00, 16'h9000);
    wr(8'h00, 16'hB000);
    idle(10);
    check(flashActive, 1'b0);
    wr(8'h00, 16'h8000);
    wr(8'h00, 16'hA000);
    idle(10);
    check(flashActive, 1'b1);
    @(posedge clock);
    pmReset <= 1'b1;
    @(posedge clock);
    pmReset <= 1'b0;
    idle(1);
    check(flashActive, 1'b0);
    check(sinkLevel, 7'h00);
    rd(8'h00, rdv);
    check(rdv, 16'h0000);
    $display("test_repeat_pm done");
  endtask

  // Main sequence
  initial begin
    reset = 1'b1;
    clockEnable = 1'b1;
    pmReset = 1'b0;
    flashPin = 1'b0;
    bus = '0;
    mismatches = 0;
    total_checks = 0;
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    test_led();
    test_flash();
    test_busy();
    test_pin();
    test_repeat_pm();
    tally_and_finish();
  end
endmodule

bind lsfs_top lsfs_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .clock(clock), .reset(reset), .clockEnable(clockEnable), .pmReset(pmReset),
  .flashPin(flashPin), .bus(bus), .regReadData(regReadData),
  .currentSinkOutputA(currentSinkOutputA), .sinkLevel(sinkLevel), .flashActive(flashActive)
);
